// ---- hmer_defs.svh ----
// constant definitions for the halt mode entry and release controller
// assumes inclusion by the package, the design module and the checker only
`ifndef HMER_DEFS_SVH
`define HMER_DEFS_SVH
// register offsets on the plain register port
`define HMER_ADDR_SYSCTL1 4'h0
`define HMER_ADDR_WU_CTRL 4'h1
`define HMER_ADDR_WU_COUNT 4'h2
`define HMER_ADDR_STATUS 4'h3
`define HMER_ADDR_PC 4'h4
// field positions in system_control_one
`define HMER_BIT_HALT 7
`define HMER_BIT_RELEASE_MODE_SELECT 6
`define HMER_BIT_PORT_LATCH_DRIVE_ENABLE 4
// field positions in warmup_control
`define HMER_BIT_WARMUP_CLOCK_SELECT 1
// reset values
`define HMER_RST_SYSCTL1 8'h00
`define HMER_RST_WU_CTRL 8'h00
`define HMER_RST_WU_COUNT 8'h01
// warm-up counts in units of 16 source clocks; one machine cycle is 4 clocks
`define HMER_WU_UNIT 16
`define HMER_MACHINE_CYCLE 4
`endif

// ---- hmer_pkg.sv ----
// types for the halt mode entry and release controller
// assumes hmer_defs.svh in the same folder
`include "hmer_defs.svh"
package hmer_pkg;
   typedef enum logic [1:0] {hmer_run, hmer_halt, hmer_warmup} hmer_state_type;
   typedef struct packed
   {
      logic [3:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } hmer_bus_type;
   typedef struct packed
   {
      logic hf_osc_en;
      logic lf_osc_en;
      logic core_run;
      logic port_drive;
      logic tg_clear;
   } hmer_ctl_type;
endpackage : hmer_pkg

// ---- hmer_ctrl.sv ----
// halt mode entry and release controller with its register port
// assumes wake inputs and resets come from outside the clk domain
//
// Summary of operation
// - writing halt bit one enters halt
// - halt stops both oscillators and core
// - state held; port drive follows enable bit
// - entering halt clears prescaler and divider
// - halted pc holds request address plus two
// - any reset ends halt, warm-up, single-clock
// - release by pin, key wakeup, voltage detect
// - release select one: level mode, pin high
// - level mode wakes on high pin
// - level mode ignores halt while pin high
// - warm-up completes even if pin drops
// - release select zero: rising edge wakes
// - edge mode halts even with pin high
// - edge within one machine cycle ignored
// - warm-up clock is the pre-halt clock
// - core stays stopped during warm-up
// - resume after halt, timing generator cleared
//
// The placing of the registers and strobed register access were left to the implementer.
`timescale 1ns/1ps
`include "hmer_defs.svh"
module hmer_ctrl
(
   input wire logic clk,
   input wire logic nrst,
   input wire logic ce,
   input wire hmer_pkg::hmer_bus_type bus,
   output logic [7:0] rdata,
   input wire logic [15:0] pc_in,
   input wire logic dual_clock,
   input wire logic release_pin,
   input wire logic key_wakeup,
   input wire logic volt_detect,
   input wire logic chip_reset_req,
   output hmer_pkg::hmer_ctl_type ctl,
   output logic [15:0] pc_hold,
   output logic wu_clk_lf
);
   import hmer_pkg::*;

   ///////////////////////////////////////////////////////////////////////
   // synchronisers for pin inputs
   logic [3:0] sync1;
   logic [3:0] sync2;
   logic pin_prev;
   always_ff @(posedge clk)
   begin
      if (!nrst)
      begin
         sync1 <= 4'h0;
         sync2 <= 4'h0;
         pin_prev <= 1'b0;
      end
      else if (ce)
      begin
         sync1 <= {chip_reset_req, volt_detect, key_wakeup, release_pin};
         sync2 <= sync1;
         pin_prev <= sync2[0];
      end
   end
   wire pin_level = sync2[0];
   wire key_s = sync2[1];
   wire volt_s = sync2[2];
   wire rst_s = sync2[3];
   wire pin_rise = pin_level & ~pin_prev;

   ///////////////////////////////////////////////////////////////////////
   // registers
   logic [7:0] sysctl1;
   logic [7:0] wu_ctrl;
   logic [7:0] wu_count;
   hmer_state_type state;
   logic [15:0] warm_cnt;
   logic [2:0] guard;
   logic lf_at_halt;
   logic reset_warm;

   wire release_mode_select = sysctl1[`HMER_BIT_RELEASE_MODE_SELECT];
   wire wr_sys = bus.wr & (bus.addr == `HMER_ADDR_SYSCTL1);
   wire wr_wuc = bus.wr & (bus.addr == `HMER_ADDR_WU_CTRL);
   wire wr_wud = bus.wr & (bus.addr == `HMER_ADDR_WU_COUNT);
   wire halt_req = wr_sys & bus.wdata[`HMER_BIT_HALT] & (state == hmer_run);
   wire halt_block = release_mode_select & pin_level;
   wire halt_go = halt_req & ~halt_block;
   wire guard_open = (guard == 3'h0);
   wire pin_wake = release_mode_select ? pin_level : (pin_rise & guard_open);
   wire wake = pin_wake | key_s | volt_s;
   wire [15:0] warm_load = {wu_count, 4'h0};
   wire warm_done = (warm_cnt == 16'h0001);

   ///////////////////////////////////////////////////////////////////////
   // read mux
   logic [7:0] next_rdata;
   always_comb
   begin
      next_rdata = 8'h00;
      unique case (bus.addr)
         `HMER_ADDR_SYSCTL1: next_rdata = sysctl1;
         `HMER_ADDR_WU_CTRL: next_rdata = wu_ctrl;
         `HMER_ADDR_WU_COUNT: next_rdata = wu_count;
         `HMER_ADDR_STATUS: next_rdata = {5'h00, reset_warm, state};
         `HMER_ADDR_PC: next_rdata = pc_hold[7:0];
         default: next_rdata = 8'h00;
      endcase
   end

   ///////////////////////////////////////////////////////////////////////
   // sequencer
   always_ff @(posedge clk)
   begin
      if (!nrst)
      begin
         sysctl1 <= `HMER_RST_SYSCTL1;
         wu_ctrl <= `HMER_RST_WU_CTRL;
         wu_count <= `HMER_RST_WU_COUNT;
         state <= hmer_warmup;
         warm_cnt <= 16'h0010;
         guard <= 3'h0;
         lf_at_halt <= 1'b0;
         reset_warm <= 1'b1;
         rdata <= 8'h00;
         ctl <= '0;
         pc_hold <= 16'h0000;
         wu_clk_lf <= 1'b0;
      end
      else if (ce)
      begin
         rdata <= bus.rd ? next_rdata : 8'h00;
         if (wr_wuc)
            wu_ctrl <= bus.wdata;
         if (wr_wud)
            wu_count <= bus.wdata;
         ctl.tg_clear <= 1'b0;
         if (guard != 3'h0)
            guard <= guard - 3'h1;
         if (rst_s)
         begin
            state <= hmer_warmup;
            sysctl1 <= `HMER_RST_SYSCTL1;
            reset_warm <= 1'b1;
            lf_at_halt <= 1'b0;
            warm_cnt <= warm_load;
            ctl <= '0;
         end
         else
         begin
            unique case (state)
               hmer_run:
               begin
                  if (wr_sys)
                     sysctl1 <= {1'b0, bus.wdata[6:0]};
                  ctl.core_run <= 1'b1;
                  ctl.hf_osc_en <= 1'b1;
                  ctl.lf_osc_en <= dual_clock;
                  ctl.port_drive <= sysctl1[`HMER_BIT_PORT_LATCH_DRIVE_ENABLE];
                  if (halt_go)
                  begin
                     state <= hmer_halt;
                     sysctl1[`HMER_BIT_HALT] <= 1'b1;
                     pc_hold <= pc_in + 16'h0002;
                     lf_at_halt <= dual_clock;
                     guard <= 3'(`HMER_MACHINE_CYCLE);
                     ctl.hf_osc_en <= 1'b0;
                     ctl.lf_osc_en <= 1'b0;
                     ctl.core_run <= 1'b0;
                     ctl.tg_clear <= 1'b1;
                     ctl.port_drive <= bus.wdata[`HMER_BIT_PORT_LATCH_DRIVE_ENABLE];
                  end
               end
               hmer_halt:
               begin
                  if (wake)
                  begin
                     state <= hmer_warmup;
                     warm_cnt <= warm_load;
                     wu_clk_lf <= lf_at_halt;
                     ctl.hf_osc_en <= ~lf_at_halt;
                     ctl.lf_osc_en <= lf_at_halt;
                  end
               end
               hmer_warmup:
               begin
                  ctl.core_run <= 1'b0;
                  if (warm_done)
                  begin
                     state <= hmer_run;
                     sysctl1[`HMER_BIT_HALT] <= 1'b0;
                     ctl.tg_clear <= 1'b1;
                     ctl.core_run <= 1'b1;
                     reset_warm <= 1'b0;
                  end
                  else
                     warm_cnt <= warm_cnt - 16'h0001;
                  if (reset_warm)
                  begin
                     ctl.hf_osc_en <= 1'b1;
                     wu_clk_lf <= 1'b0;
                  end
               end
               default: state <= hmer_run;
            endcase
         end
      end
   end
endmodule : hmer_ctrl

// ---- hmer_props.sv ----
// port checker for the halt entry and release controller
// assumes a bind onto hmer_ctrl
`timescale 1ns/1ps
`include "hmer_defs.svh"
module hmer_props
(
   input wire logic clk,
   input wire logic nrst,
   input wire logic ce,
   input wire hmer_pkg::hmer_bus_type bus,
   input wire logic [15:0] pc_in,
   input wire logic dual_clock,
   input wire logic release_pin,
   input wire logic chip_reset_req,
   input wire hmer_pkg::hmer_ctl_type ctl,
   input wire logic [15:0] pc_hold,
   input wire logic wu_clk_lf
);
   import hmer_pkg::*;
   logic release_mode_select;
   wire off = !ctl.hf_osc_en && !ctl.lf_osc_en;
   wire w0 = ce && bus.wr && bus.addr == `HMER_ADDR_SYSCTL1;
   wire ent = w0 && ctl.core_run && bus.wdata[7:6] == 2'b10;
   wire lreq = w0 && ctl.core_run && bus.wdata[7:6] == 2'b11;
   default clocking @(posedge clk); endclocking
   default disable iff (!nrst);
   always_ff @(posedge clk)
      release_mode_select <= !nrst ? 1'b0 : w0 ? bus.wdata[6] : release_mode_select;
   ////////
   property p_entry; ent |=> off && !ctl.core_run && ctl.tg_clear; endproperty
   a_entry: assert property (p_entry) else $error("halt entry");
   property p_pc; ent |=> pc_hold == $past(pc_in) + 16'h0002; endproperty
   a_pc: assert property (p_pc) else $error("held pc");
   property p_warm; $rose(!off) && !ctl.core_run |-> (!ctl.core_run) [*8]; endproperty
   a_warm: assert property (p_warm) else $error("warm-up run");
   property p_done; $rose(!off) |-> ##[1:1000] ctl.core_run; endproperty
   a_done: assert property (p_done) else $error("warm-up end");
   property p_res; $rose(ctl.core_run) |-> ctl.tg_clear; endproperty
   a_res: assert property (p_res) else $error("resume clear");
   property p_lvl; (release_mode_select && off && release_pin) [*6] |-> 1'b0; endproperty
   a_lvl: assert property (p_lvl) else $error("level wake");
   property p_edge; !release_mode_select && off && $past(off, 6) && $rose(release_pin) |-> ##[1:6] !off;
   endproperty
   a_edge: assert property (p_edge) else $error("edge wake");
   property p_ign; (release_mode_select && release_pin) [*4] ##0 lreq |=> ctl.core_run; endproperty
   a_ign: assert property (p_ign) else $error("halt not refused");
   property p_wuclk; $rose(!off) && !ctl.core_run |-> wu_clk_lf == dual_clock; endproperty
   a_wuclk: assert property (p_wuclk) else $error("warm-up clock");
   property p_rst; chip_reset_req [*4] |-> !ctl.core_run; endproperty
   a_rst: assert property (p_rst) else $error("reset run");
   c_halt: cover property (ent);
   c_wake: cover property ($rose(ctl.core_run));
   c_ign: cover property (lreq);
endmodule : hmer_props

// ---- hmer_wake_src.sv ----
// wake source driving the release pin
// assumes start is a one-cycle pulse in the clk domain
`timescale 1ns/1ps
module hmer_wake_src
(
   input wire logic clk,
   input wire logic start,
   input wire logic [7:0] delay,
   input wire logic [7:0] width,
   output logic release_pin
);
   logic [8:0] cnt = 9'h1FF;
   wire [8:0] next_cnt = start ? 9'h000 : cnt + {8'h00, cnt != 9'h1FF};
   initial release_pin = 1'b0;
   always @(posedge clk)
   begin
      cnt <= next_cnt;
      release_pin <= next_cnt >= {1'b0, delay} && next_cnt < {1'b0, delay} + {1'b0, width};
   end
endmodule : hmer_wake_src

// ---- test_halt_mode_entry_release.sv ----
// self-checking bench for the halt entry and release controller
// assumes the package, design, checker and wake source compiled first
`timescale 1ns/1ps
module test_halt_mode_entry_release;
   import hmer_pkg::*;
   logic clk = 1'b0;
   logic nrst = 1'b0;
   logic dual_clock = 1'b0;
   logic chip_reset_req = 1'b0;
   logic start = 1'b0;
   logic [1:0] src = 2'b00;
   logic [7:0] dly = 8'h00;
   logic [7:0] width = 8'h14;
   logic [15:0] pc_in = 16'h1234;
   logic [7:0] rdata;
   logic [15:0] pc_hold;
   logic release_pin;
   logic wu_clk_lf;
   hmer_bus_type bus = '0;
   hmer_ctl_type ctl;
   int failures = 0;
   int samples_checked = 0;
   wire [2:0] run3 = {ctl.hf_osc_en, ctl.lf_osc_en, ctl.core_run};
   initial forever #20 clk = ~clk;
   hmer_ctrl i_hmer_ctrl (.clk(clk), .nrst(nrst), .ce(1'b1), .bus(bus), .rdata(rdata),
      .pc_in(pc_in), .dual_clock(dual_clock), .release_pin(release_pin), .key_wakeup(src[0]),
      .volt_detect(src[1]), .chip_reset_req(chip_reset_req), .ctl(ctl), .pc_hold(pc_hold),
      .wu_clk_lf(wu_clk_lf));
   hmer_wake_src i_hmer_wake_src (.clk(clk), .start(start), .delay(dly), .width(width),
      .release_pin(release_pin));
   ////////
   task chk(input bit ok);
      samples_checked++;
      if (!ok)
      begin
         failures++;
         $display("CHECK FAILED at %0t: mismatch", $time);
      end
   endtask : chk
   task stop_test;
      $display("failures %0d checked %0d", failures, samples_checked);
      if (failures == 0 && samples_checked > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : stop_test
   task wr(input logic [3:0] a, input logic [7:0] d, input logic k);
      @(posedge clk);
      bus <= '{a, d, 1'b1, 1'b0};
      start <= k;
      @(posedge clk);
      bus.wr <= 1'b0;
      start <= 1'b0;
   endtask : wr
   task rd(input logic [3:0] a, input logic [7:0] e, input logic [7:0] m);
      @(posedge clk);
      bus <= '{a, 8'h00, 1'b0, 1'b1};
      @(posedge clk);
      bus.rd <= 1'b0;
      #1 chk((rdata & m) === e);
   endtask : rd
   task wait_run;
      int n;
      n = 0;
      while (ctl.core_run !== 1'b1 && n < 2000)
      begin
         @(posedge clk);
         #1 n++;
      end
      chk(n < 2000);
      if (n >= 2000)
         stop_test;
   endtask : wait_run
   ////////
   initial
   begin
      repeat (5) @(posedge clk);
      nrst <= 1'b1;
      wait_run;
      rd(4'h2, 8'h01, 8'hFF);
      rd(4'hF, 8'h00, 8'hFF);
      dual_clock <= 1'b1;
      wr(4'h0, 8'h80, 1'b1);
      #1 chk(ctl.tg_clear === 1'b1 && pc_hold === 16'h1236);
      rd(4'h4, 8'h36, 8'hFF);
      rd(4'h3, 8'h01, 8'h03);
      repeat (30) @(posedge clk);
      #1 chk(run3 === 3'b000);
      wr(4'hF, 8'h00, 1'b1);
      wait_run;
      chk(wu_clk_lf === 1'b1);
      rd(4'h0, 8'h00, 8'h80);
      dual_clock <= 1'b0;
      width <= 8'h40;
      wr(4'h0, 8'h40, 1'b1);
      repeat (6) @(posedge clk);
      wr(4'h0, 8'hC0, 1'b0);
      rd(4'h0, 8'h40, 8'hC0);
      chk(ctl.core_run === 1'b1);
      repeat (70) @(posedge clk);
      #1 chk(release_pin === 1'b0);
      width <= 8'h02;
      dly <= 8'h20;
      wr(4'h0, 8'hC0, 1'b1);
      repeat (20) @(posedge clk);
      #1 chk(run3 === 3'b000);
      wait_run;
      for (int i = 0; i < 2; i++)
      begin
         wr(4'h0, {3'b100, i[0], 4'h0}, 1'b0);
         repeat (10) @(posedge clk);
         #1 chk(run3 === 3'b000 && ctl.port_drive === i[0]);
         src[i] <= 1'b1;
         wait_run;
         src <= 2'b00;
      end
      wr(4'h0, 8'h80, 1'b0);
      chip_reset_req <= 1'b1;
      repeat (6) @(posedge clk);
      #1 chk(run3 === 3'b000);
      chip_reset_req <= 1'b0;
      wait_run;
      stop_test;
   end
endmodule : test_halt_mode_entry_release
bind hmer_ctrl hmer_props i_hmer_props (.clk(clk), .nrst(nrst), .ce(ce), .bus(bus),
   .pc_in(pc_in), .dual_clock(dual_clock), .release_pin(release_pin),
   .chip_reset_req(chip_reset_req), .ctl(ctl), .pc_hold(pc_hold), .wu_clk_lf(wu_clk_lf));
